// *** verilog/gpio_mux_pkg.sv ***
// shared constants for the programmable i/o port block
package gpio_mux_pkg;

    // pin positions: 123 ports plus the input-only pin in the large package
    localparam int unsigned PIN_POSITIONS       = 124;
    // the small package: 87 ports plus the input-only pin
    localparam int unsigned SMALL_PIN_POSITIONS = 88;
    // position of the input-only pin (port 8, bit 5)
    localparam int unsigned INPUT_ONLY_POS      = 69;
    // pins covered by one pull-up control bit
    localparam int unsigned PULL_GROUP          = 4;
    // 32-bit words per per-pin register
    localparam int unsigned MAX_WORDS           = 4;
    localparam int unsigned VEC_BITS            = MAX_WORDS * 32;

    // register byte offsets (per-pin registers span four words each)
    localparam logic [6:0] OFS_DIR  = 7'h00;
    localparam logic [6:0] OFS_DATA = 7'h10;
    localparam logic [6:0] OFS_FSA  = 7'h20;
    localparam logic [6:0] OFS_FSB  = 7'h30;
    localparam logic [6:0] OFS_FSC  = 7'h40;
    localparam logic [6:0] OFS_PULL = 7'h50;
    localparam logic [6:0] OFS_MODE = 7'h54;

    // reset values: all inputs, all plain port, pull-ups off, single-chip mode
    localparam logic [VEC_BITS-1:0] RST_DIR  = '0;
    localparam logic [VEC_BITS-1:0] RST_DATA = '0;
    localparam logic [VEC_BITS-1:0] RST_FS   = '0;
    localparam logic [31:0]         RST_PULL = 32'h0000_0000;
    localparam logic                RST_MODE = 1'b0;

    // mode register field: external bus owns its pins when set
    localparam int unsigned MODE_EXT_BIT = 0;

    // second_level_select_group_three bits 3..6 inside the level-b vector
    localparam int unsigned B3_LO = 27;
    localparam int unsigned B3_HI = 30;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verilog/pin_mux_if.sv ***
// carrier between the register core and the per-pin output selector
`timescale 1ns/10ps
`default_nettype none
interface pin_mux_if #(
    parameter int unsigned N = 128
);
    logic [N-1:0] latch;     // port output latch
    logic [N-1:0] sel_a;     // first-level select
    logic [N-1:0] sel_b;     // second-level select
    logic [N-1:0] sel_c;     // third-level select
    logic [N-1:0] p1;        // first peripheral output
    logic [N-1:0] p2;        // second peripheral output
    logic [N-1:0] p3;        // third peripheral output
    logic [N-1:0] drive_val; // selected output level

    modport regs (output latch, sel_a, sel_b, sel_c, p1, p2, p3, input drive_val);
    modport mux  (input latch, sel_a, sel_b, sel_c, p1, p2, p3, output drive_val);
endinterface
`default_nettype wire

// *** verilog/pin_function_mux.sv ***
// per-pin three-level output function selector
`timescale 1ns/10ps
`default_nettype none
module pin_function_mux
    import gpio_mux_pkg::*;
#(
    parameter int unsigned          N        = VEC_BITS,
    parameter logic [VEC_BITS-1:0]  HAS2     = '1,
    parameter logic [VEC_BITS-1:0]  HAS3     = '0
) (
    pin_mux_if.mux m
);
    // one selector per pin; purely combinational, the top registers the result
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            wire lvl_c;   // third level: first or third function
            wire lvl_b;   // second level result
            assign lvl_c = m.sel_c[i] ? m.p3[i] : m.p1[i]; // [R16]
            // three-function pins: b high hands over to c, b low gives the second
            assign lvl_b = HAS3[i] ? (m.sel_b[i] ? lvl_c : m.p2[i]) // [R13]
                         : HAS2[i] ? (m.sel_b[i] ? m.p2[i] : m.p1[i]) // [R12]
                         : m.p1[i];
            // level b is only looked at once level a picks a peripheral
            assign m.drive_val[i] = m.sel_a[i] ? lvl_b : m.latch[i]; // [R11] [R14]
        end
    endgenerate
endmodule
`default_nettype wire

// *** verilog/programmable_io_port_mux.sv ***
// programmable i/o port block with function select and axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] 87 or 123 ports, input-only pin excluded
// [R2] every pin independently input or output
// [R3] one pull-up bit per four pins
// [R4] input-only pin: no pull-up, no direction bit
// [R5] one direction bit per pin
// [R6] data write to latch, read senses pin
// [R7] bus-owned pins keep bits in expansion mode
// [R8] software sets input for peripheral inputs
// [R9] software programs a, b, c for outputs
// [R10] converter output: plain port, direction input
// [R11] level a picks latch or peripheral
// [R12] level b picks first or second
// [R13] three-function pins: level b enables c
// [R14] level b only counts when a peripheral
// [R15] group three bits 3..6 skip input paths
// [R16] level c picks first or third
// [R17] pull-up only while pin is input
// [R18] reset: all inputs, all plain port
module programmable_io_port_mux
    import gpio_mux_pkg::*;
#(
    parameter int unsigned         PINS           = PIN_POSITIONS,
    parameter int unsigned         INPUT_ONLY_IDX = INPUT_ONLY_POS,
    parameter logic [VEC_BITS-1:0] HAS2_MASK      = '1,
    parameter logic [VEC_BITS-1:0] HAS3_MASK      = 128'h0000_0000_0000_0000_0400_0000_0000_0000,
    parameter logic [VEC_BITS-1:0] BUS_PIN_MASK   = 128'h0000_0000_0000_0000_0000_FFFF_FFFF_FFFF
) (
    input  wire  logic            clock,
    input  wire  logic            rst,
    input  wire  logic            ce,
    // axi4-lite slave
    input  wire  logic [6:0]      s_awaddr,
    input  wire  logic            s_awvalid,
    output logic                  s_awready,
    input  wire  logic [31:0]     s_wdata,
    input  wire  logic [3:0]      s_wstrb,
    input  wire  logic            s_wvalid,
    output logic                  s_wready,
    output logic [1:0]            s_bresp,
    output logic                  s_bvalid,
    input  wire  logic            s_bready,
    input  wire  logic [6:0]      s_araddr,
    input  wire  logic            s_arvalid,
    output logic                  s_arready,
    output logic [31:0]           s_rdata,
    output logic [1:0]            s_rresp,
    output logic                  s_rvalid,
    input  wire  logic            s_rready,
    // pins and peripherals
    input  wire  logic [PINS-1:0] pin_in,
    output logic [PINS-1:0]       pin_out,
    output logic [PINS-1:0]       pin_oe_n,
    output logic [PINS-1:0]       pin_pull_en,
    input  wire  logic [PINS-1:0] periph_out1,
    input  wire  logic [PINS-1:0] periph_out2,
    input  wire  logic [PINS-1:0] periph_out3,
    output logic [3:0]            analog_path_sel
);
    localparam int unsigned VEC    = VEC_BITS;
    localparam int unsigned GROUPS = (PINS + PULL_GROUP - 1) / PULL_GROUP;

    // refuse sizes the fixed four-word map cannot hold
    generate
        if (PINS == 0 || PINS > VEC || INPUT_ONLY_IDX >= PINS || GROUPS > 32) begin : g_bad
            $error("programmable_io_port_mux: pin count or input-only index out of range");
        end
    endgenerate

    // pins that exist; bits above read as zero and never drive
    localparam logic [VEC-1:0] LIVE     = {VEC{1'b1}} >> (VEC - PINS); // [R1]
    // pins that own a direction bit: all live ones except the input-only pin
    localparam logic [VEC-1:0] NO_DIR   = LIVE & ~({{(VEC-1){1'b0}}, 1'b1} << INPUT_ONLY_IDX); // [R4]
    localparam logic [31:0]    PULL_LIVE = 32'hFFFF_FFFF >> (32 - GROUPS);

    // register state
    logic [VEC-1:0] dir_r;        // 1 = output
    logic [VEC-1:0] latch_r;      // port output latch
    logic [VEC-1:0] fsa_r;        // first-level select
    logic [VEC-1:0] fsb_r;        // second-level select
    logic [VEC-1:0] fsc_r;        // third-level select
    logic [31:0]    pull_r;       // one bit per group of four
    logic           mode_r;       // external bus / expansion mode
    logic [VEC-1:0] pin_sync_r;   // sampled pin levels for readback

    // bus state
    logic           awready_r;
    logic           wready_r;
    logic           bvalid_r;
    logic [1:0]     bresp_r;
    logic           arready_r;
    logic           rvalid_r;
    logic [31:0]    rdata_r;
    logic [1:0]     rresp_r;
    logic           aw_held_r;    // write address captured
    logic           w_held_r;     // write data captured
    logic [6:0]     waddr_r;
    logic [31:0]    wdata_r;
    logic [3:0]     wstrb_r;

    // output flops
    logic [VEC-1:0] pin_out_r;
    logic [VEC-1:0] pin_oe_n_r;
    logic [VEC-1:0] pull_en_r;
    logic [3:0]     analog_sel_r;

    // merge one word into a per-pin vector under byte strobes
    function automatic logic [VEC-1:0] upd(input logic [VEC-1:0] old,
                                           input logic [1:0]     word,
                                           input logic [31:0]    data,
                                           input logic [3:0]     strb);
        logic [VEC-1:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                v[word*32 + b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return v;
    endfunction

    // ---------------- write channel handshake ----------------
    wire aw_take;                 // address accepted this cycle
    wire w_take;                  // data accepted this cycle
    wire wr_go;                   // both halves present: commit now
    wire aw_held_nxt;
    wire w_held_nxt;
    wire bvalid_nxt;
    assign aw_take     = s_awvalid & awready_r;
    assign w_take      = s_wvalid & wready_r;
    assign wr_go       = aw_held_r & w_held_r & ~bvalid_r;
    assign aw_held_nxt = (aw_held_r | aw_take) & ~wr_go;
    assign w_held_nxt  = (w_held_r | w_take) & ~wr_go;
    assign bvalid_nxt  = wr_go | (bvalid_r & ~s_bready);

    // write decode on the captured address
    wire [2:0] wa_type;           // which register family
    wire       wa_vec;            // one of the per-pin vectors
    wire       wa_pull;
    wire       wa_mode;
    wire       wa_ok;
    assign wa_type = waddr_r[6:4];
    assign wa_vec  = wa_type < OFS_PULL[6:4];
    assign wa_pull = waddr_r[6:2] == OFS_PULL[6:2];
    assign wa_mode = waddr_r[6:2] == OFS_MODE[6:2];
    assign wa_ok   = wa_vec | wa_pull | wa_mode;

    wire wr_dir;
    wire wr_data;
    wire wr_fsa;
    wire wr_fsb;
    wire wr_fsc;
    assign wr_dir  = wr_go & (wa_type == OFS_DIR[6:4]);
    assign wr_data = wr_go & (wa_type == OFS_DATA[6:4]);
    assign wr_fsa  = wr_go & (wa_type == OFS_FSA[6:4]);
    assign wr_fsb  = wr_go & (wa_type == OFS_FSB[6:4]);
    assign wr_fsc  = wr_go & (wa_type == OFS_FSC[6:4]);

    // pins the external bus owns while expansion mode is on
    wire [VEC-1:0] prot;
    assign prot = {VEC{mode_r}} & BUS_PIN_MASK;

    // next register values; protected bits keep their contents
    wire [VEC-1:0] dir_nxt;
    wire [VEC-1:0] latch_nxt;
    wire [VEC-1:0] pull_upd;      // pull word merged in the low lanes
    assign pull_upd  = upd({{(VEC-32){1'b0}}, pull_r}, 2'h0, wdata_r, wstrb_r);
    assign dir_nxt   = ((upd(dir_r, waddr_r[3:2], wdata_r, wstrb_r) & ~prot) // [R2] [R5]
                     | (dir_r & prot)) & NO_DIR; // [R7] [R4]
    assign latch_nxt = ((upd(latch_r, waddr_r[3:2], wdata_r, wstrb_r) & ~prot) // [R6]
                     | (latch_r & prot)) & LIVE; // [R7]

    // ---------------- read channel ----------------
    wire           ar_take;       // read address accepted this cycle
    wire           rvalid_nxt;
    wire [2:0]     ra_type;
    wire           ra_pull;
    wire           ra_mode;
    wire           ra_ok;
    wire [VEC-1:0] rd_vec;        // per-pin vector being read
    wire [31:0]    rd_word;
    assign ar_take    = s_arvalid & arready_r;
    assign rvalid_nxt = ar_take | (rvalid_r & ~s_rready);
    assign ra_type    = s_araddr[6:4];
    assign ra_pull    = s_araddr[6:2] == OFS_PULL[6:2];
    assign ra_mode    = s_araddr[6:2] == OFS_MODE[6:2];
    assign ra_ok      = (ra_type < OFS_PULL[6:4]) | ra_pull | ra_mode;
    // the data register reads the sensed pin, not the latch
    assign rd_vec  = (ra_type == OFS_DIR[6:4])  ? dir_r
                   : (ra_type == OFS_DATA[6:4]) ? pin_sync_r // [R6]
                   : (ra_type == OFS_FSA[6:4])  ? fsa_r
                   : (ra_type == OFS_FSB[6:4])  ? fsb_r
                   : fsc_r;
    assign rd_word = ra_pull ? pull_r
                   : ra_mode ? {31'h0000_0000, mode_r}
                   : (ra_type < OFS_PULL[6:4]) ? rd_vec[s_araddr[3:2]*32 +: 32]
                   : 32'h0000_0000;

    // ---------------- bus handshake flops ----------------
    // ready drops while a half is held or a response waits, so one write at a time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else if (ce) begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= ~aw_held_nxt & ~bvalid_nxt;
            wready_r  <= ~w_held_nxt & ~bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (wr_go) begin
                bresp_r <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // capture write halves as they are taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waddr_r <= 7'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                waddr_r <= s_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else if (ce) begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_word;
                rresp_r <= ra_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ---------------- register file ----------------
    // reset leaves every pin a plain-port input
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dir_r   <= RST_DIR; // [R18]
            latch_r <= RST_DATA;
            fsa_r   <= RST_FS; // [R18]
            fsb_r   <= RST_FS;
            fsc_r   <= RST_FS;
            pull_r  <= RST_PULL;
            mode_r  <= RST_MODE;
        end else if (ce) begin
            if (wr_dir) begin
                dir_r <= dir_nxt;
            end
            if (wr_data) begin
                latch_r <= latch_nxt;
            end
            if (wr_fsa) begin
                fsa_r <= upd(fsa_r, waddr_r[3:2], wdata_r, wstrb_r) & LIVE;
            end
            if (wr_fsb) begin
                fsb_r <= upd(fsb_r, waddr_r[3:2], wdata_r, wstrb_r) & LIVE;
            end
            if (wr_fsc) begin
                fsc_r <= upd(fsc_r, waddr_r[3:2], wdata_r, wstrb_r) & LIVE;
            end
            if (wr_go && wa_pull) begin
                pull_r <= pull_upd[31:0] & PULL_LIVE; // [R3]
            end
            if (wr_go && wa_mode && wstrb_r[0]) begin
                mode_r <= wdata_r[MODE_EXT_BIT];
            end
        end
    end

    // ---------------- pin side ----------------
    // widen the pin-side ports to the fixed vector width
    wire [VEC-1:0] pin_in_v;
    wire [VEC-1:0] p1_v;
    wire [VEC-1:0] p2_v;
    wire [VEC-1:0] p3_v;
    assign pin_in_v = {{(VEC-PINS){1'b0}}, pin_in};
    assign p1_v     = {{(VEC-PINS){1'b0}}, periph_out1};
    assign p2_v     = {{(VEC-PINS){1'b0}}, periph_out2};
    assign p3_v     = {{(VEC-PINS){1'b0}}, periph_out3};

    // spread each group bit over its four pins
    wire [VEC-1:0] pull_exp;
    genvar gi;
    generate
        for (gi = 0; gi < VEC; gi++) begin : g_pull
            assign pull_exp[gi] = (gi < PINS) ? pull_r[gi / PULL_GROUP] : 1'b0; // [R3]
        end
    endgenerate

    // output function selection lives in the leaf module
    pin_mux_if #(.N(VEC)) mux_bus ();
    assign mux_bus.latch = latch_r;
    assign mux_bus.sel_a = fsa_r;
    assign mux_bus.sel_b = fsb_r;
    assign mux_bus.sel_c = fsc_r;
    assign mux_bus.p1    = p1_v;
    assign mux_bus.p2    = p2_v;
    assign mux_bus.p3    = p3_v;

    pin_function_mux #(
        .N    (VEC),
        .HAS2 (HAS2_MASK),
        .HAS3 (HAS3_MASK)
    ) u_mux (
        .m (mux_bus)
    );

    // all pin outputs are registered; this costs a cycle of peripheral latency
    // but keeps pin timing independent of the select tree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_out_r    <= '0;
            pin_oe_n_r   <= '1;
            pull_en_r    <= '0;
            pin_sync_r   <= '0;
            analog_sel_r <= 4'h0;
        end else if (ce) begin
            pin_out_r    <= mux_bus.drive_val & LIVE;
            pin_oe_n_r   <= ~(dir_r & NO_DIR); // [R2] [R4]
            pull_en_r    <= pull_exp & ~dir_r & NO_DIR; // [R17] [R4]
            pin_sync_r   <= pin_in_v & LIVE; // [R6]
            // these bits also pick level b for pins 27..30 and steer converter/expansion routing, never pin_in
            analog_sel_r <= fsb_r[B3_HI:B3_LO]; // [R15]
        end
    end

    assign s_awready       = awready_r;
    assign s_wready        = wready_r;
    assign s_bvalid        = bvalid_r;
    assign s_bresp         = bresp_r;
    assign s_arready       = arready_r;
    assign s_rvalid        = rvalid_r;
    assign s_rdata         = rdata_r;
    assign s_rresp         = rresp_r;
    assign pin_out         = pin_out_r[PINS-1:0];
    assign pin_oe_n        = pin_oe_n_r[PINS-1:0];
    assign pin_pull_en     = pull_en_r[PINS-1:0];
    assign analog_path_sel = analog_sel_r;

    // ---------------- checks ----------------
    // flags the first enabled cycle after reset
    logic after_rst_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            after_rst_r <= 1'b1;
        end else if (ce) begin
            after_rst_r <= 1'b0;
        end
    end

    a_reset_plain_input: assert property (@(posedge clock) disable iff (rst) // [R18]
        after_rst_r |-> (dir_r == '0) && (fsa_r == '0) && (pin_oe_n_r == '1))
        else $error("state after reset is not plain-port input");

    a_input_only_pin: assert property (@(posedge clock) disable iff (rst) // [R4]
        pin_oe_n_r[INPUT_ONLY_IDX] && !pull_en_r[INPUT_ONLY_IDX] && !dir_r[INPUT_ONLY_IDX])
        else $error("input-only pin driven or pulled up");

    a_pull_when_input: assert property (@(posedge clock) disable iff (rst) // [R17]
        ce |=> ((pull_en_r & ~pin_oe_n_r) == '0)
               && (pull_en_r == ($past(pull_exp) & ~$past(dir_r) & NO_DIR)))
        else $error("pull-up wrong for pin direction or group");

    a_bus_pins_kept: assert property (@(posedge clock) disable iff (rst) // [R7]
        (ce && wr_go && mode_r) |=>
            (((dir_r ^ $past(dir_r)) | (latch_r ^ $past(latch_r))) & BUS_PIN_MASK) == '0)
        else $error("bus-owned pin bits changed in expansion mode");

    a_port_latch_out: assert property (@(posedge clock) disable iff (rst) // [R11]
        ce |=> ((pin_out_r ^ $past(latch_r)) & ~$past(fsa_r) & LIVE) == '0)
        else $error("plain port pin not driving its latch");

    a_second_level: assert property (@(posedge clock) disable iff (rst) // [R12] [R14]
        ce |=> ((pin_out_r ^ $past(p2_v)) & $past(fsa_r & fsb_r)
                & HAS2_MASK & ~HAS3_MASK & LIVE) == '0)
        else $error("second peripheral output not selected");

    a_third_level: assert property (@(posedge clock) disable iff (rst) // [R13] [R16]
        ce |=> ((pin_out_r ^ $past(p3_v)) & $past(fsa_r & fsb_r & fsc_r)
                & HAS3_MASK & LIVE) == '0)
        else $error("third peripheral output not selected");

    a_data_reads_pin: assert property (@(posedge clock) disable iff (rst) // [R6]
        (ce && ar_take && s_araddr[6:4] == OFS_DATA[6:4]) |=>
            rvalid_r && (rdata_r == $past(pin_sync_r[s_araddr[3:2]*32 +: 32])))
        else $error("data read does not return sensed pin levels");

    a_write_answer: assert property (@(posedge clock) disable iff (rst) // [R2]
        (ce && wr_go && wa_type == OFS_DIR[6:4] && wstrb_r == 4'hF && !mode_r
         && waddr_r[3:2] == 2'h0) |=>
            bvalid_r && (dir_r[31:0] == ($past(wdata_r) & NO_DIR[31:0])))
        else $error("direction write not applied or not answered");

    a_resp_hold: assert property (@(posedge clock) disable iff (rst)
        (bvalid_r && !s_bready) |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before it was taken");

endmodule
`default_nettype wire

// *** tb/pin_partner.sv ***
// external devices on the port pins: resolves each pin's level
`timescale 1ns/10ps
`default_nettype none
module pin_partner
    import gpio_mux_pkg::*;
#(
    parameter int unsigned PINS = PIN_POSITIONS
) (
    input  wire logic            clock,
    input  wire logic [PINS-1:0] pin_out,
    input  wire logic [PINS-1:0] pin_oe_n,
    input  wire logic [PINS-1:0] pin_pull_en,
    output logic      [PINS-1:0] pin_in
);
    // undriven, unpulled lines flip every cycle so a stale level never passes
    logic [PINS-1:0] float_r = '0;
    always @(posedge clock) begin
        float_r <= ~float_r;
    end
    // driven pin shows the driver, else the pull-up wins, else it floats
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pull_en | float_r));
endmodule
`default_nettype wire

// *** tb/programmable_io_port_mux_tb.sv ***
// self-checking bench for the programmable i/o port block
`timescale 1ns/10ps
`default_nettype none
module programmable_io_port_mux_tb
    import gpio_mux_pkg::*;
;
    localparam int unsigned P = PIN_POSITIONS;
    typedef struct packed {
        logic [6:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic [1:0]  r;
    } row_t;
    // address, written word, expected readback, expected response
    row_t rows [6] = '{
        '{7'h00, 32'hAAAA5555, 32'hAAAA5555, RESP_OKAY},
        '{7'h08, 32'h000000F0, 32'h000000D0, RESP_OKAY},
        '{7'h0C, 32'hFFFFFFFF, 32'h0FFFFFFF, RESP_OKAY},
        '{7'h20, 32'h12345678, 32'h12345678, RESP_OKAY},
        '{7'h50, 32'hFFFFFFFF, 32'h7FFFFFFF, RESP_OKAY},
        '{7'h58, 32'hFFFFFFFF, 32'h00000000, RESP_SLVERR}};
    logic clock = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [6:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata, rd_v;
    logic [3:0] s_wstrb = 4'hF, analog_path_sel;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    logic s_bready = 1'b1, s_rready = 1'b1;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rs_v;
    logic [P-1:0] pin_in, pin_out, pin_oe_n, pin_pull_en;
    // peripheral 1 low, 2 and 3 high, so the chosen source shows
    logic [P-1:0] periph_out1 = '0, periph_out2 = '1, periph_out3 = '1;
    int n_fail = 0, checks = 0, cyc = 0;

    always #10 clock = ~clock;

    programmable_io_port_mux dut_u (.clock, .rst, .ce, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en, .periph_out1,
        .periph_out2, .periph_out3, .analog_path_sel);
    pin_partner #(.PINS(P)) far_u (.clock, .pin_out, .pin_oe_n, .pin_pull_en, .pin_in);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // settle just past the edge; every bus change starts here
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic da, dw, ra, rw;
        da = 1'b0;
        dw = 1'b0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        while (!(da && dw)) begin
            ra = s_awready & ~da;
            rw = s_wready & ~dw;
            tick;
            if (ra)
                s_awvalid <= 1'b0;
            if (rw)
                s_wvalid <= 1'b0;
            da = da | ra;
            dw = dw | rw;
        end
        while (!s_bvalid)
            tick;
        rs_v = s_bresp;
        tick;
    endtask
    task automatic rd(input logic [6:0] a);
        logic ra;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            ra = s_arready;
            tick;
        end while (!ra);
        s_arvalid <= 1'b0;
        while (!s_rvalid)
            tick;
        rd_v = s_rdata;
        rs_v = s_rresp;
        tick;
    endtask

    // hang guard: far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test;
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        check(32'({analog_path_sel, &pin_oe_n, |pin_pull_en}), 32'h2);
        rst <= 1'b0;
        tick;
        tick;
        rd(OFS_FSA);
        check(rd_v, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            check(32'(rs_v), 32'(rows[i].r));
            rd(rows[i].a);
            check(rd_v, rows[i].x);
            check(32'(rs_v), 32'(rows[i].r));
        end
        // pins 33..35 stay inputs for the pulled group
        wr(OFS_PULL, 32'h0002_0100);
        wr(OFS_DIR + 7'h04, 32'h0400_0001);
        tick;
        check(32'({pin_pull_en[35:32], pin_pull_en[71:68]}), 32'hE0);
        check(32'({pin_oe_n[35:32], pin_oe_n[71:68]}), 32'hE2);
        // every level a/b/c code on a three-way and a two-way pin
        for (int i = 0; i < 8; i++) begin
            logic [2:0] s;
            logic e58, e32;
            s = i[2:0];
            wr(OFS_DATA + 7'h04, {5'h0, ~s[0], 25'h0, ~s[0]});
            wr(OFS_FSA + 7'h04, {5'h0, s[2], 25'h0, s[2]});
            wr(OFS_FSB + 7'h04, {5'h0, s[1], 25'h0, s[1]});
            wr(OFS_FSC + 7'h04, {5'h0, s[0], 25'h0, s[0]});
            tick;
            e58 = s[2] ? (s[1] ? s[0] : 1'b1) : ~s[0];
            e32 = s[2] ? s[1] : ~s[0];
            check(32'({pin_out[58], pin_out[32]}), 32'({e58, e32}));
            rd(OFS_DATA + 7'h04);
            check(32'({rd_v[26], rd_v[1]}), 32'({e58, 1'b1}));
        end
        // expansion mode: the low 48 pins keep their bits
        wr(OFS_MODE, 32'h1);
        wr(OFS_DIR + 7'h04, 32'h0);
        rd(OFS_DIR + 7'h04);
        check(rd_v, 32'h0000_0001);
        wr(OFS_MODE, 32'h0);
        wr(OFS_FSB, 32'h5800_0000);
        tick;
        check(32'(analog_path_sel), 32'hB);
        // clock enable low freezes the pin outputs
        ce <= 1'b0;
        periph_out2 <= '0;
        tick;
        tick;
        check(32'(pin_out[32]), 32'h1);
        ce <= 1'b1;
        tick;
        tick;
        check(32'(pin_out[32]), 32'h0);
        // second reset in mid-run
        rst <= 1'b1;
        tick;
        check(32'({analog_path_sel, &pin_oe_n, |pin_pull_en}), 32'h2);
        rst <= 1'b0;
        tick;
        tick;
        rd(OFS_DIR);
        check(rd_v, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
